// ===== pld_cell_pkg.sv
// Purpose: shared constants and carriers for the macrocell group
// Assumes: 32-bit register bus with byte addresses, one word per register
// Notes: configuration words reset to zero, which steers every term to the sum with no literal chosen, so every term stays low
package pld_cell_pkg;
    localparam int N_MC = 16;              // macrocells per group
    localparam int N_PT = 5;               // local product terms per macrocell
    localparam int N_PT_ALL = N_MC * N_PT; // product terms in the group
    localparam int CHAIN = 8;              // lending chain length
    localparam int MAX_SETS = 3;           // borrowed sets per macrocell
    localparam int N_FAB = 36;             // fabric signals entering the group
    localparam int N_LIT = N_FAB + N_MC;   // fabric plus shareable terms
    localparam int N_OE_SLOTS = 16;        // address room for global enables
    localparam int N_OE_SRC = 2 + 2 * N_MC; // enable pins, pins, macrocells
    localparam int N_PIN = N_MC + 5;       // synchronised pin inputs
    localparam int PT_WORDS = 4;           // true lo/hi, complement lo/hi
    localparam int SEL_W = 3;              // steering code width

    // register map, byte addresses
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_FAB_LO = 12'h008;
    localparam logic [11:0] OFS_FAB_HI = 12'h00c;
    localparam logic [11:0] OFS_GCLK = 12'h010;
    localparam logic [11:0] OFS_OE_BASE = 12'h040;
    localparam logic [11:0] OFS_MC_BASE = 12'h080;
    localparam logic [11:0] OFS_SEL_BASE = 12'h0c0;
    localparam logic [11:0] OFS_PT_BASE = 12'h400;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic [31:0] CFG_RESET = 32'h0;
    localparam logic [N_PIN-1:0] PIN_SYNC_RESET = 21'h040000; // clear pin idles high

    // product term steering codes
    localparam logic [2:0] ST_OR = 3'h0;
    localparam logic [2:0] ST_PRESET = 3'h1;
    localparam logic [2:0] ST_CLEAR = 3'h2;
    localparam logic [2:0] ST_CLOCK = 3'h3;
    localparam logic [2:0] ST_CLKEN = 3'h4;
    localparam logic [2:0] ST_SECOND = 3'h5;
    localparam logic [2:0] ST_SHARE = 3'h6;
    // register modes
    localparam logic [2:0] RM_D = 3'h0;
    localparam logic [2:0] RM_T = 3'h1;
    localparam logic [2:0] RM_JK = 3'h2;
    localparam logic [2:0] RM_SR = 3'h3;
    localparam logic [2:0] RM_BYPASS = 3'h4;
    // clock modes and pin enable modes
    localparam logic [1:0] CM_GLOBAL = 2'h0;
    localparam logic [1:0] CM_GATED = 2'h1;
    localparam logic [1:0] CM_ARRAY = 2'h2;
    localparam logic [1:0] OEM_OFF = 2'h0;
    localparam logic [1:0] OEM_ON = 2'h1;
    localparam logic [1:0] OEM_GLOBAL = 2'h2;

    typedef struct packed {
        logic [12:0] pad;
        logic [3:0] oe_idx;
        logic [1:0] oe_mode;
        logic [1:0] borrow;
        logic lend;
        logic pwr_high;
        logic gclr_en;
        logic fast_in;
        logic xor_inv;
        logic net_sel;
        logic [1:0] clk_mode;
        logic [2:0] reg_mode;
    } mc_cfg_s;
    typedef struct packed {
        logic inv1;
        logic pin1;
        logic inv0;
        logic pin0;
    } gclk_cfg_s;
    typedef struct packed {
        logic inv;
        logic [5:0] src;
    } oe_cfg_s;
endpackage

// ===== pld_macrocell_group.sv
// Purpose: one group of sixteen configurable macrocells with routing and pin control
// Assumes: all pins and the register bus are sampled on CLK; configuration via bus
// Notes: register clocks, presets and clears are modelled as CLK-rate events
// Notes on behaviour
// RQ1 - five local product terms per macrocell
// RQ2 - each term steered to sum or register controls
// RQ3 - register acts as D, T, JK, SR or bypass
// RQ4 - global, gated global or array clocking
// RQ5 - gated clock updates only when enable high
// RQ6 - array clock built from fed-back signals
// RQ7 - two global nets, either pin, either polarity
// RQ8 - term preset and clear, active high
// RQ9 - optional per-register global clear, active low
// RQ10 - enhanced variant: chosen power-up level
// RQ11 - other variant: registers power up low
// RQ12 - direct pin path into register data
// RQ13 - sixteen inverted shareable terms per group
// RQ14 - up to twenty terms into the sum
// RQ15 - at most three borrowed sets of five
// RQ16 - two chains of eight, borrow from below
// RQ17 - chain bottom only lends, top only borrows
// RQ18 - fabric signals gated by enable bits
// RQ19 - pin driver: global enable or tied
// RQ20 - tied off is input, tied on drives
// RQ21 - six or ten global output enables
// RQ22 - pin and macrocell feedback kept separate
// RQ23 - groups of sixteen, thirty-six fabric inputs
// RQ24 - conventional next-state tables on clock event
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
module pld_macrocell_group
    import pld_cell_pkg::*;
#(
    parameter int N_OE = 6,        // global output enables, 6 or 10
    parameter bit ENHANCED = 1'b1  // per-register power-up level available
) (
    input logic CLK,
    input logic SYS_RST,
    input logic [11:0] AVS_ADDRESS,
    input logic AVS_READ,
    input logic AVS_WRITE,
    input logic [31:0] AVS_WRITEDATA,
    input logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input logic GLOBAL_CLOCK_PIN_A,
    input logic GLOBAL_CLOCK_PIN_B,
    input logic GLOBAL_CLEAR_PIN_LOW,
    input logic [1:0] OE_PIN_IN,
    input logic [N_MC-1:0] IO_PIN_IN,
    output logic [N_MC-1:0] IO_PIN_OUT,
    output logic [N_MC-1:0] IO_PIN_OE
);
    // pin synchroniser stages
    logic [N_PIN-1:0] pin_meta_reg;
    logic [N_PIN-1:0] pin_sync_reg;
    logic [N_MC-1:0] io_in;
    logic gclk_a;
    logic gclk_b;
    logic gclr_low;
    logic [1:0] oe_pin;
    // configuration store
    logic run_reg; // low holds registers at power-up level
    logic [N_FAB-1:0] fab_en_reg;
    gclk_cfg_s gclk_reg;
    oe_cfg_s oe_mem [N_OE_SLOTS];
    logic [31:0] mc_mem [N_MC];
    logic [N_PT*SEL_W-1:0] sel_mem [N_MC];
    logic [31:0] pt_mem [N_PT_ALL*PT_WORDS];
    mc_cfg_s cfg [N_MC];
    // bus side
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [11:0] bus_addr;
    logic [3:0] i_oe;
    logic [3:0] i_mc;
    logic [3:0] i_sel;
    logic [8:0] i_pt;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    // logic array and macrocells
    logic [N_MC-1:0] mc_fb_reg; // registered macrocell feedback
    logic [N_MC-1:0] mc_q_reg;
    logic [N_MC-1:0] clk_pt_prev_reg;
    logic [N_MC-1:0] io_out_reg;
    logic [N_MC-1:0] io_oe_reg;
    logic [N_FAB-1:0] fab_in;
    logic [N_LIT-1:0] lits;
    logic [N_PT_ALL-1:0] pt_val;
    logic [N_MC-1:0] shr_exp;
    logic [N_MC-1:0] or_local;
    logic [N_MC-1:0] sec_sum;
    logic [N_MC-1:0] pre_sum;
    logic [N_MC-1:0] clr_sum;
    logic [N_MC-1:0] clk_pt;
    logic [N_MC-1:0] ce_sum;
    logic [N_MC-1:0] lend_eff;
    logic [N_MC-1:0] borrowed;
    logic [N_MC-1:0] comb_out;
    logic [N_MC-1:0] d_in;
    logic [N_MC-1:0] clr_vec;
    logic [N_MC-1:0] clk_ev;
    logic [N_MC-1:0] mc_out;
    logic chain_ok;
    logic [1:0] gnet;
    logic [1:0] gnet_prev_reg;
    logic [1:0] gedge;
    logic [N_OE_SRC-1:0] oe_src;
    logic [N_OE_SLOTS-1:0] goe;

    // true when a lies inside a window of n words from base
    function automatic logic in_win(input logic [11:0] a, input logic [11:0] base, input int n);
        return (int'(a) >= int'(base)) && (int'(a) < int'(base) + n * 4);
    endfunction

    // word index inside a window
    function automatic logic [8:0] word_idx(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] diff;
        diff = a - base;
        return diff[10:2];
    endfunction

    // byte-lane merge of a write into the current word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // one product term; a term with no literal chosen stays low
    function automatic logic pt_eval(input logic [N_LIT-1:0] t, input logic [N_LIT-1:0] c,
                                     input logic [N_LIT-1:0] l);
        if ((t | c) == '0) return 1'b0;
        return &((~t | l) & (~c | ~l));
    endfunction

    // next state of the register for each mode
    function automatic logic ff_next(input logic [2:0] mode, input logic q, input logic d,
                                     input logic s);
        case (mode)
            RM_T: return q ^ d;
            RM_JK: return (d & ~q) | (~s & q);
            RM_SR: return (d & ~s) ? 1'b1 : ((s & ~d) ? 1'b0 : q); // both high holds
            default: return d;
        endcase
    endfunction

    // pins come from outside the clock domain
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_meta_reg <= PIN_SYNC_RESET;
            pin_sync_reg <= PIN_SYNC_RESET;
        end else begin
            pin_meta_reg <= {OE_PIN_IN, GLOBAL_CLEAR_PIN_LOW, GLOBAL_CLOCK_PIN_B,
                             GLOBAL_CLOCK_PIN_A, IO_PIN_IN};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign io_in = pin_sync_reg[N_MC-1:0];
    assign gclk_a = pin_sync_reg[N_MC];
    assign gclk_b = pin_sync_reg[N_MC+1];
    assign gclr_low = pin_sync_reg[N_MC+2];
    assign oe_pin = pin_sync_reg[N_MC+4:N_MC+3];

    // address decode and read mux, low address bits ignored
    assign bus_addr = {AVS_ADDRESS[11:2], 2'b00};
    always_comb begin
        // windows of sixteen words keep only the low four index bits
        i_oe = 4'(word_idx(bus_addr, OFS_OE_BASE));
        i_mc = 4'(word_idx(bus_addr, OFS_MC_BASE));
        i_sel = 4'(word_idx(bus_addr, OFS_SEL_BASE));
        i_pt = word_idx(bus_addr, OFS_PT_BASE);
        rd_word = '0; // unmapped space reads zero
        if (bus_addr == OFS_CTRL) begin
            rd_word = {31'h0, run_reg};
        end else if (bus_addr == OFS_STATUS) begin
            rd_word = {io_in, mc_fb_reg};
        end else if (bus_addr == OFS_FAB_LO) begin
            rd_word = fab_en_reg[31:0];
        end else if (bus_addr == OFS_FAB_HI) begin
            rd_word = {28'h0, fab_en_reg[N_FAB-1:32]};
        end else if (bus_addr == OFS_GCLK) begin
            rd_word = {28'h0, gclk_reg};
        end else if (in_win(bus_addr, OFS_OE_BASE, N_OE_SLOTS)) begin
            rd_word = {25'h0, oe_mem[i_oe]};
        end else if (in_win(bus_addr, OFS_MC_BASE, N_MC)) begin
            rd_word = mc_mem[i_mc];
        end else if (in_win(bus_addr, OFS_SEL_BASE, N_MC)) begin
            rd_word = {17'h0, sel_mem[i_sel]};
        end else if (in_win(bus_addr, OFS_PT_BASE, N_PT_ALL * PT_WORDS)) begin
            rd_word = pt_mem[i_pt];
        end
        wr_word = be_merge(rd_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    end

    // one wait state: low for one cycle after each request is seen
    always_ff @(posedge CLK) begin
        if (SYS_RST) wait_reg <= 1'b1;
        else wait_reg <= ~((AVS_READ | AVS_WRITE) & wait_reg);
    end

    // read data captured one edge before the completing edge
    always_ff @(posedge CLK) begin
        if (SYS_RST) rdata_reg <= CFG_RESET;
        else if (AVS_READ && wait_reg) rdata_reg <= rd_word;
    end

    // configuration writes take effect at the completing edge
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            run_reg <= 1'b0;
            fab_en_reg <= '0;
            gclk_reg <= '0;
            for (int i = 0; i < N_OE_SLOTS; i++) oe_mem[i] <= '0;
            for (int i = 0; i < N_MC; i++) mc_mem[i] <= CFG_RESET;
            for (int i = 0; i < N_MC; i++) sel_mem[i] <= '0;
            for (int i = 0; i < N_PT_ALL * PT_WORDS; i++) pt_mem[i] <= CFG_RESET;
        end else if (AVS_WRITE && !wait_reg) begin
            if (bus_addr == OFS_CTRL) begin
                run_reg <= wr_word[CTRL_RUN_BIT];
            end else if (bus_addr == OFS_FAB_LO) begin
                fab_en_reg[31:0] <= wr_word;
            end else if (bus_addr == OFS_FAB_HI) begin
                fab_en_reg[N_FAB-1:32] <= wr_word[N_FAB-33:0];
            end else if (bus_addr == OFS_GCLK) begin
                gclk_reg <= wr_word[3:0];
            end else if (in_win(bus_addr, OFS_OE_BASE, N_OE_SLOTS)) begin
                oe_mem[i_oe] <= wr_word[6:0];
            end else if (in_win(bus_addr, OFS_MC_BASE, N_MC)) begin
                mc_mem[i_mc] <= wr_word;
            end else if (in_win(bus_addr, OFS_SEL_BASE, N_MC)) begin
                sel_mem[i_sel] <= wr_word[N_PT*SEL_W-1:0];
            end else if (in_win(bus_addr, OFS_PT_BASE, N_PT_ALL * PT_WORDS)) begin
                pt_mem[i_pt] <= wr_word;
            end
        end
    end

    // product terms; feedback is registered so a bypassed cell cannot form a loop
    always_comb begin
        for (int m = 0; m < N_MC; m++) cfg[m] = mc_cfg_s'(mc_mem[m]);
        // fabric carries pins and macrocell outputs on separate lines
        fab_in = {oe_pin, gclk_b, gclk_a, io_in, mc_fb_reg} & fab_en_reg; // RQ18 RQ22 RQ23
        // last term of each cell may become its inverted shared term
        for (int m = 0; m < N_MC; m++) begin
            shr_exp[m] = 1'b0;
            if (sel_mem[m][(N_PT-1)*SEL_W +: SEL_W] == ST_SHARE) begin
                // a shared term sees fabric only, never other shared terms
                shr_exp[m] = ~pt_eval(pt_mask(m * N_PT + N_PT - 1, 1'b0),
                                      pt_mask(m * N_PT + N_PT - 1, 1'b1),
                                      {{N_MC{1'b0}}, fab_in}); // RQ13
            end
        end
        lits = {shr_exp, fab_in}; // RQ13
        for (int k = 0; k < N_PT_ALL; k++) begin
            pt_val[k] = pt_eval(pt_mask(k, 1'b0), pt_mask(k, 1'b1), lits); // RQ1
        end
    end

    // literal masks of one term from the term store
    function automatic logic [N_LIT-1:0] pt_mask(input int k, input logic comp);
        int w;
        w = k * PT_WORDS + (comp ? 2 : 0);
        return {pt_mem[w+1][N_LIT-33:0], pt_mem[w]};
    endfunction

    // global clock nets and their rising edges
    assign gnet[0] = (gclk_reg.pin0 ? gclk_b : gclk_a) ^ gclk_reg.inv0; // RQ7
    assign gnet[1] = (gclk_reg.pin1 ? gclk_b : gclk_a) ^ gclk_reg.inv1; // RQ7
    assign gedge = gnet & ~gnet_prev_reg;

    // term steering, expander chains and register controls
    always_comb begin
        or_local = '0;
        sec_sum = '0;
        pre_sum = '0;
        clr_sum = '0;
        clk_pt = '0;
        ce_sum = '0;
        chain_ok = 1'b1;
        for (int m = 0; m < N_MC; m++) begin
            for (int p = 0; p < N_PT; p++) begin
                case (sel_mem[m][p*SEL_W +: SEL_W]) // RQ2
                    ST_OR: or_local[m] = or_local[m] | pt_val[m*N_PT+p];
                    ST_PRESET: pre_sum[m] = pre_sum[m] | pt_val[m*N_PT+p];
                    ST_CLEAR: clr_sum[m] = clr_sum[m] | pt_val[m*N_PT+p];
                    ST_CLOCK: clk_pt[m] = clk_pt[m] | pt_val[m*N_PT+p];
                    ST_CLKEN: ce_sum[m] = ce_sum[m] | pt_val[m*N_PT+p];
                    ST_SECOND: sec_sum[m] = sec_sum[m] | pt_val[m*N_PT+p];
                    default: ; // shared or unused term
                endcase
            end
        end
        for (int m = 0; m < N_MC; m++) begin
            // top of a chain has nobody above to lend to
            lend_eff[m] = cfg[m].lend && ((m % CHAIN) != CHAIN - 1); // RQ17
        end
        for (int m = 0; m < N_MC; m++) begin
            borrowed[m] = 1'b0;
            chain_ok = 1'b1;
            // walk down the own chain only, stopping at the first gap
            for (int j = 1; j <= MAX_SETS; j++) begin
                if (chain_ok && (j <= int'(cfg[m].borrow)) && (j <= m % CHAIN)) begin // RQ15 RQ16
                    if (lend_eff[m-j]) borrowed[m] = borrowed[m] | or_local[m-j]; // RQ14
                    else chain_ok = 1'b0;
                end
            end
            // a lending cell gives its sum away and keeps only what it borrows
            comb_out[m] = ((lend_eff[m] ? 1'b0 : or_local[m]) | borrowed[m]) ^ cfg[m].xor_inv;
            d_in[m] = cfg[m].fast_in ? io_in[m] : comb_out[m]; // RQ12
            clr_vec[m] = clr_sum[m] | (cfg[m].gclr_en & ~gclr_low); // RQ8 RQ9
            case (cfg[m].clk_mode) // RQ4
                CM_GLOBAL: clk_ev[m] = gedge[cfg[m].net_sel];
                CM_GATED: clk_ev[m] = gedge[cfg[m].net_sel] & ce_sum[m]; // RQ5
                CM_ARRAY: clk_ev[m] = clk_pt[m] & ~clk_pt_prev_reg[m]; // RQ6
                default: clk_ev[m] = 1'b0;
            endcase
            mc_out[m] = (cfg[m].reg_mode == RM_BYPASS) ? comb_out[m] : mc_q_reg[m]; // RQ3
        end
    end

    // macrocell registers; clear beats preset, both beat the clock
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mc_q_reg <= '0;
        end else begin
            for (int m = 0; m < N_MC; m++) begin
                if (!run_reg) begin
                    mc_q_reg[m] <= ENHANCED ? cfg[m].pwr_high : 1'b0; // RQ10 RQ11
                end else if (clr_vec[m]) begin
                    mc_q_reg[m] <= 1'b0; // RQ8 RQ9
                end else if (pre_sum[m]) begin
                    mc_q_reg[m] <= 1'b1; // RQ8
                end else if (clk_ev[m]) begin
                    mc_q_reg[m] <= ff_next(cfg[m].reg_mode, mc_q_reg[m], d_in[m],
                                           sec_sum[m]); // RQ3 RQ24
                end
            end
        end
    end

    // edge history and fabric feedback
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gnet_prev_reg <= '0;
            clk_pt_prev_reg <= '0;
            mc_fb_reg <= '0;
        end else begin
            gnet_prev_reg <= gnet;
            clk_pt_prev_reg <= clk_pt;
            mc_fb_reg <= mc_out; // RQ22
        end
    end

    // global output enables from enable pins, pins or macrocells
    assign oe_src = {mc_fb_reg, io_in, oe_pin};
    always_comb begin
        goe = '0;
        for (int i = 0; i < N_OE_SLOTS; i++) begin
            if (i < N_OE && int'(oe_mem[i].src) < N_OE_SRC) begin
                goe[i] = oe_src[oe_mem[i].src] ^ oe_mem[i].inv; // RQ21
            end
        end
    end

    // pin drivers stay off until the array runs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            io_out_reg <= '0;
            io_oe_reg <= '0;
        end else begin
            for (int m = 0; m < N_MC; m++) begin
                io_out_reg[m] <= run_reg & mc_out[m];
                case (cfg[m].oe_mode) // RQ19
                    OEM_ON: io_oe_reg[m] <= run_reg; // RQ20
                    OEM_GLOBAL: io_oe_reg[m] <= run_reg & goe[cfg[m].oe_idx];
                    default: io_oe_reg[m] <= 1'b0; // RQ20
                endcase
            end
        end
    end

    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign IO_PIN_OUT = io_out_reg;
    assign IO_PIN_OE = io_oe_reg;

    // bus answer comes one cycle after a request
    a_bus_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest did not drop");

    // per-macrocell checks
    for (genvar g = 0; g < N_MC; g++) begin : g_chk
        a_clear_wins: assert property ( // RQ8
            @(posedge CLK) disable iff (SYS_RST) run_reg && clr_vec[g] |=> !mc_q_reg[g])
            else $error("clear did not force low");
        a_preset_sets: assert property ( // RQ8
            @(posedge CLK) disable iff (SYS_RST)
            run_reg && pre_sum[g] && !clr_vec[g] |=> mc_q_reg[g])
            else $error("preset did not force high");
        a_gated_hold: assert property ( // RQ5
            @(posedge CLK) disable iff (SYS_RST)
            run_reg && cfg[g].clk_mode == CM_GATED && !ce_sum[g] && !pre_sum[g] && !clr_vec[g]
            |=> $stable(mc_q_reg[g]))
            else $error("gated register moved without enable");
        a_dff_capture: assert property ( // RQ3
            @(posedge CLK) disable iff (SYS_RST)
            run_reg && cfg[g].reg_mode == RM_D && clk_ev[g] && !pre_sum[g] && !clr_vec[g]
            |=> mc_q_reg[g] == $past(d_in[g]))
            else $error("d register missed its data");
        a_pwrup_low: assert property ( // RQ11
            @(posedge CLK) disable iff (SYS_RST) !ENHANCED && !run_reg |=> !mc_q_reg[g])
            else $error("register not low at power-up");
        a_pwrup_chosen: assert property ( // RQ10
            @(posedge CLK) disable iff (SYS_RST)
            ENHANCED && !run_reg |=> mc_q_reg[g] == $past(cfg[g].pwr_high))
            else $error("power-up level not applied");
        a_oe_tied_off: assert property ( // RQ20
            @(posedge CLK) disable iff (SYS_RST) cfg[g].oe_mode == OEM_OFF |=> !IO_PIN_OE[g])
            else $error("tied-off pin drove");
        a_oe_tied_on: assert property ( // RQ20
            @(posedge CLK) disable iff (SYS_RST)
            run_reg && cfg[g].oe_mode == OEM_ON |=> IO_PIN_OE[g])
            else $error("tied-on pin not driving");
        a_top_no_lend: assert property ( // RQ17
            @(posedge CLK) disable iff (SYS_RST)
            (g % CHAIN == CHAIN - 1) && or_local[g] && !cfg[g].xor_inv |-> comb_out[g])
            else $error("chain top lent its terms");
    end
endmodule

// ===== pin_board.sv
// Purpose: board logic facing the sixteen user pins
// Assumes: no pull on the pins; the bench chooses what the board drives
// Notes: a pin whose driver is on shows the device value, else the board value
module pin_board (
    input logic [15:0] pin_oe,
    input logic [15:0] pin_out,
    input logic [15:0] drive,
    output logic [15:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // wire resolution; the board backs off wherever the device drives, so no contention
    assign level = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// ===== pld_macrocell_group_tb_top.sv
// Purpose: self-checking bench for one macrocell group
// Assumes: bus requests held until waitrequest is low, pins pass two sync flops
// Notes: clock pins are pulsed slowly so every edge is seen after sync
module pld_macrocell_group_tb_top;
    import pld_cell_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, rd = 0, wr = 0, wait_req, gca = 0, gcb = 0, gclr_n = 1;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [15:0] lvl, pin_out, pin_oe, drive = 16'h0;
    logic [1:0] oe_in = 2'h0; // dedicated enable pins
    int failures = 0, n_tests = 0;
    // the design under test, six global enables, power-up level selectable
    pld_macrocell_group #(.N_OE(6), .ENHANCED(1'b1)) pld_macrocell_group_inst (
        .CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .GLOBAL_CLOCK_PIN_A(gca), .GLOBAL_CLOCK_PIN_B(gcb),
        .GLOBAL_CLEAR_PIN_LOW(gclr_n), .OE_PIN_IN(oe_in), .IO_PIN_IN(lvl),
        .IO_PIN_OUT(pin_out), .IO_PIN_OE(pin_oe));
    // board on the far side of the pins
    pin_board pin_board_inst (.pin_oe(pin_oe), .pin_out(pin_out), .drive(drive), .level(lvl));
    // free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // verdict and end of run
    task summarize;
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one comparison, four-state exact
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus access; request held until waitrequest is seen low at a rising edge
    task acc(input int w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        addr <= a;
        wr <= (w != 0);
        rd <= (w == 0);
        wdata <= d;
        // waitrequest and read data are taken at the rising edge, as the slave sees them
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wait_req === 1'b0) break;
        end
        r = rdata;
        rd <= 0;
        wr <= 0;
        if (i == 20) begin
            failures++;
            $display("Error at %0t: bus timeout", $time);
            summarize();
        end
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 0;
        acc(0, OFS_CTRL, 0, q);
        chk(q, CFG_RESET);
        acc(0, 12'h020, 0, q);
        chk(q, 32'h0);
        // cell 0 powers up high, cell 1 low, while the group is stopped
        acc(1, OFS_MC_BASE, 32'h200, q);
        // cell output reaches the status word through registered feedback
        repeat (2) @(posedge clk);
        acc(0, OFS_STATUS, 0, q);
        chk(q & 32'h3, 32'h1);
        // cell 0: D, global net 0 from pin A, fast pin input, driver off; cell 1 driver on
        drive <= 16'h1;
        acc(1, OFS_MC_BASE, 32'h80, q);
        acc(1, OFS_MC_BASE + 12'h4, 32'h2000, q);
        acc(1, OFS_CTRL, 32'h1, q);
        gca <= 1;
        repeat (5) @(posedge clk);
        chk({31'h0, pin_out[0]}, 32'h1);
        chk({16'h0, pin_oe}, 32'h2);
        gca <= 0;
        // global clear enabled on cell 0 and pulled low
        acc(1, OFS_MC_BASE, 32'h180, q);
        gclr_n <= 0;
        repeat (5) @(posedge clk);
        chk({31'h0, pin_out[0]}, 32'h0);
        gclr_n <= 1;
        // pin still reads high while its cell holds low: separate feedback paths
        acc(0, OFS_STATUS, 0, q);
        chk(q & 32'h10001, 32'h10000);
        // net 0 from inverted pin B: only the falling edge of B clocks
        drive <= 16'h0;
        acc(1, OFS_GCLK, 32'h3, q);
        gcb <= 1;
        repeat (4) @(posedge clk);
        drive <= 16'h1;
        repeat (4) @(posedge clk);
        gcb <= 0;
        repeat (5) @(posedge clk);
        chk({31'h0, pin_out[0]}, 32'h1);
        // cell 2 bypassed: one term on pin 3, driver on global enable 0 from enable pin 0
        acc(1, OFS_FAB_LO, 32'h80000, q);
        acc(1, OFS_PT_BASE + 12'h0a0, 32'h80000, q);
        acc(1, OFS_MC_BASE + 12'h8, 32'h4004, q);
        drive <= 16'h9;
        oe_in <= 2'h1;
        repeat (5) @(posedge clk);
        chk({30'h0, pin_oe[2], pin_out[2]}, 32'h3);
        drive <= 16'h1;
        oe_in <= 2'h0;
        repeat (5) @(posedge clk);
        chk({30'h0, pin_oe[2], pin_out[2]}, 32'h0);
        // enable slot 0 inverted: the pin drives while the enable pin is low
        acc(1, OFS_OE_BASE, 32'h40, q);
        repeat (3) @(posedge clk);
        chk({31'h0, pin_oe[2]}, 32'h1);
        summarize();
    end
endmodule
